/* rtl/bcsch_top.sv */
// cycle status outputs and coprocessor handshake of the processor
`timescale 1ns/1ps
module bcsch_top #(
  parameter int DIV = bcsch_pkg::BCSCH_PHASE_DIV
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RSTN,
  // active high processor clear
  input wire logic CHIP_CLEAR,
  // next cycle description from the core
  input wire bcsch_pkg::bcsch_req_t NEXT_REQ,
  input wire logic NEXT_VALID,
  output logic NEXT_READY,
  // coprocessor inputs
  input wire logic COPRO_BUSY,
  input wire logic COPRO_ABSENT,
  // memory side pipelined status
  output logic READ_NOT_WRITE,
  output logic MEM_CYCLE_NEXT_N,
  output logic MAP_ENABLE_N,
  output logic INSTR_FETCH_N,
  output logic NEXT_ADDR_FOLLOWS,
  // coprocessor strobe
  output logic COPRO_INSTR_N,
  // results to the core
  output logic CYCLE_STROBE,
  output logic RESET_VECTOR,
  output logic UNDEF_TRAP,
  output logic COPRO_DONE
);
  typedef enum logic [1:0] {
    ST_CLEAR,
    ST_RUN,
    ST_COPRO
  } bcsch_state_t;

  typedef struct packed {
    bcsch_state_t state;
    bcsch_pkg::bcsch_stat_t stat;
    logic cop_n;
    logic strobe;
    logic rst_vec;
    bcsch_pkg::bcsch_cpres_t cpres;
  } bcsch_st_t;

  // whole sequencer state in one register, apart from the phase counter
  bcsch_st_t st_ff;
  bcsch_st_t nxt_st;
  // phase strobes, each one system clock wide
  logic ph1_end;
  logic ph2_end;
  bcsch_pkg::bcsch_cpres_t verdict;

  // processor phase strobes from the system clock
  bcsch_phase_gen #(
    .DIV(DIV)
  ) u_phase (
    .clk(CLK),
    .rstn(RSTN),
    .ph1_end(ph1_end),
    .ph2_end(ph2_end)
  );

  // status for a cycle that is being announced
  function automatic bcsch_pkg::bcsch_stat_t announce(
    input bcsch_pkg::bcsch_req_t r
  );
    bcsch_pkg::bcsch_stat_t s;
    s.rd_not_wr = r.write;
    s.mem_next_n = (r.kind == bcsch_pkg::BCSCH_CYC_IDLE) ||
               (r.kind == bcsch_pkg::BCSCH_CYC_COPRO);
    s.map_en_n = ~r.xlate;
    s.fetch_n = (r.kind != bcsch_pkg::BCSCH_CYC_FETCH);
    s.follows = r.follows;
    return s;
  endfunction

  // status shown while clear holds the core in no-ops
  function automatic bcsch_pkg::bcsch_stat_t nop_stat();
    bcsch_pkg::bcsch_stat_t s;
    s.rd_not_wr = bcsch_pkg::BCSCH_RST_RNW;
    s.mem_next_n = bcsch_pkg::BCSCH_RST_MEM_N;
    s.map_en_n = bcsch_pkg::BCSCH_RST_MAP_N;
    s.fetch_n = bcsch_pkg::BCSCH_RST_FETCH_N;
    s.follows = bcsch_pkg::BCSCH_RST_FOLLOW;
    return s;
  endfunction

  // absent wins over busy: a missing unit must trap even if busy floats
  function automatic bcsch_pkg::bcsch_cpres_t copro_verdict(
    input logic absent,
    input logic busy
  );
    if (absent) begin
      return bcsch_pkg::BCSCH_CP_UNDEF;
    end
    if (!busy) begin
      return bcsch_pkg::BCSCH_CP_DONE;
    end
    return bcsch_pkg::BCSCH_CP_NONE;
  endfunction

  // leave the handshake: strobe back high, verdict pulse, core resumes
  function automatic bcsch_st_t finish_copro(
    input bcsch_st_t s,
    input bcsch_pkg::bcsch_cpres_t v
  );
    bcsch_st_t r;
    r = s;
    r.cpres = v;
    r.cop_n = 1'h1;
    r.state = ST_RUN;
    return r;
  endfunction

  // verdict as the pins stand now; acted on only at a phase one end
  assign verdict = copro_verdict(COPRO_ABSENT, COPRO_BUSY);

  // sequencer: status changes only at the end of phase two, or at once on clear, so that it
  // is valid through the last part of the preceding cycle
  always_comb begin
    nxt_st = st_ff;
    nxt_st.strobe = 1'h0;
    nxt_st.rst_vec = 1'h0;
    nxt_st.cpres = bcsch_pkg::BCSCH_CP_NONE;
    case (st_ff.state)
      ST_CLEAR: begin
        nxt_st.stat = nop_stat();
        nxt_st.cop_n = bcsch_pkg::BCSCH_RST_COP_N;
        if (!CHIP_CLEAR && ph2_end) begin
          nxt_st.state = ST_RUN;
          nxt_st.rst_vec = 1'h1;
        end
      end
      ST_RUN: begin
        if (ph2_end) begin
          if (NEXT_VALID) begin
            nxt_st.stat = announce(NEXT_REQ);
            nxt_st.strobe = 1'h1;
            if (NEXT_REQ.kind == bcsch_pkg::BCSCH_CYC_COPRO) begin
              nxt_st.cop_n = 1'h0;
              nxt_st.state = ST_COPRO;
            end
          end else begin
            // no work: an internal cycle with no memory request
            nxt_st.stat.mem_next_n = 1'h1;
            nxt_st.stat.follows = 1'h0;
          end
        end
      end
      ST_COPRO: begin
        // the core is stalled until the coprocessor answers
        if (ph1_end && verdict != bcsch_pkg::BCSCH_CP_NONE) begin
          nxt_st = finish_copro(nxt_st, verdict);
        end
      end
      default: begin
        nxt_st.state = ST_CLEAR;
      end
    endcase
    // clear overrides everything and aborts any handshake
    if (CHIP_CLEAR) begin
      nxt_st.state = ST_CLEAR;
      nxt_st.stat = nop_stat();
      nxt_st.cop_n = bcsch_pkg::BCSCH_RST_COP_N;
      nxt_st.strobe = 1'h0;
      nxt_st.cpres = bcsch_pkg::BCSCH_CP_NONE;
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      st_ff.state <= ST_CLEAR;
      // same no-op status that clear shows, so both agree from the start
      st_ff.stat <= {bcsch_pkg::BCSCH_RST_RNW, bcsch_pkg::BCSCH_RST_MEM_N,
                     bcsch_pkg::BCSCH_RST_MAP_N,
                     bcsch_pkg::BCSCH_RST_FETCH_N,
                     bcsch_pkg::BCSCH_RST_FOLLOW};
      st_ff.cop_n <= bcsch_pkg::BCSCH_RST_COP_N;
      st_ff.strobe <= 1'h0;
      st_ff.rst_vec <= 1'h0;
      st_ff.cpres <= bcsch_pkg::BCSCH_CP_NONE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // core may offer a cycle only when not clearing or stalled
  assign NEXT_READY = (st_ff.state == ST_RUN) && ph2_end && !CHIP_CLEAR;

  // pipelined pins come straight from flops, so they stand a full cycle
  assign READ_NOT_WRITE = st_ff.stat.rd_not_wr;
  assign MEM_CYCLE_NEXT_N = st_ff.stat.mem_next_n;
  assign MAP_ENABLE_N = st_ff.stat.map_en_n;
  assign INSTR_FETCH_N = st_ff.stat.fetch_n;
  assign NEXT_ADDR_FOLLOWS = st_ff.stat.follows;
  assign COPRO_INSTR_N = st_ff.cop_n;

  // one cycle result pulses toward the core
  assign CYCLE_STROBE = st_ff.strobe;
  assign RESET_VECTOR = st_ff.rst_vec;
  assign UNDEF_TRAP = (st_ff.cpres == bcsch_pkg::BCSCH_CP_UNDEF);
  assign COPRO_DONE = (st_ff.cpres == bcsch_pkg::BCSCH_CP_DONE);
endmodule

/* inc/bcsch_pkg.sv */
// shared types and constants for the bus cycle status block
package bcsch_pkg;
  // cycle kinds requested by the core sequencer
  typedef enum logic [1:0] {
    BCSCH_CYC_IDLE,
    BCSCH_CYC_FETCH,
    BCSCH_CYC_DATA,
    BCSCH_CYC_COPRO
  } bcsch_kind_t;

  // one upcoming cycle as described by the core
  typedef struct packed {
    bcsch_kind_t kind;
    logic write;
    logic follows;
    logic xlate;
  } bcsch_req_t;

  // pipelined status pins toward memory
  typedef struct packed {
    logic rd_not_wr;
    logic mem_next_n;
    logic map_en_n;
    logic fetch_n;
    logic follows;
  } bcsch_stat_t;

  // coprocessor verdicts
  typedef enum logic [1:0] {
    BCSCH_CP_NONE,
    BCSCH_CP_DONE,
    BCSCH_CP_UNDEF
  } bcsch_cpres_t;

  // reset values of the status pins
  localparam logic BCSCH_RST_RNW = 1'h0;
  localparam logic BCSCH_RST_MEM_N = 1'h0;
  localparam logic BCSCH_RST_MAP_N = 1'h1;
  localparam logic BCSCH_RST_FETCH_N = 1'h1;
  localparam logic BCSCH_RST_FOLLOW = 1'h1;
  localparam logic BCSCH_RST_COP_N = 1'h1;
  // phase divider: system clocks per processor phase
  localparam int BCSCH_PHASE_DIV = 2;
  localparam int BCSCH_DIV_W = 4;
endpackage

/* rtl/bcsch_phase_gen.sv */
// phase enable generator for the two phase processor clock
`timescale 1ns/1ps
module bcsch_phase_gen #(
  parameter int DIV = bcsch_pkg::BCSCH_PHASE_DIV
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // phase strobes
  output logic ph1_end,
  output logic ph2_end
);
  typedef struct packed {
    logic [bcsch_pkg::BCSCH_DIV_W-1:0] cnt;
    logic phase;
  } bcsch_pg_st_t;

  bcsch_pg_st_t st_ff;
  bcsch_pg_st_t nxt_st;

  // count out each phase, then toggle
  always_comb begin
    nxt_st = st_ff;
    if (st_ff.cnt == bcsch_pkg::BCSCH_DIV_W'(DIV - 1)) begin
      nxt_st.cnt = '0;
      nxt_st.phase = ~st_ff.phase;
    end else begin
      nxt_st.cnt = st_ff.cnt + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // one cycle pulse at the end of each phase (phase 0 is phase one)
  assign ph1_end = (st_ff.cnt == bcsch_pkg::BCSCH_DIV_W'(DIV - 1)) &&
                   !st_ff.phase;
  assign ph2_end = (st_ff.cnt == bcsch_pkg::BCSCH_DIV_W'(DIV - 1)) &&
                   st_ff.phase;
endmodule

/* testbench/bcsch_top_sva.sv */
// assertions on the cycle status and coprocessor pins
`timescale 1ns/1ps
module bcsch_top_sva #(
  parameter int DIV = bcsch_pkg::BCSCH_PHASE_DIV
) (
  // clock, reset, clear
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic CHIP_CLEAR,
  // core request
  input wire bcsch_pkg::bcsch_req_t NEXT_REQ,
  input wire logic NEXT_VALID,
  input wire logic NEXT_READY,
  // coprocessor
  input wire logic COPRO_BUSY,
  input wire logic COPRO_ABSENT,
  input wire logic COPRO_INSTR_N,
  input wire logic UNDEF_TRAP,
  input wire logic COPRO_DONE,
  // memory status
  input wire logic READ_NOT_WRITE,
  input wire logic MEM_CYCLE_NEXT_N,
  input wire logic MAP_ENABLE_N,
  input wire logic INSTR_FETCH_N,
  input wire logic NEXT_ADDR_FOLLOWS
);
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RSTN);
  // taken request, split by kind
  wire tk = NEXT_READY && NEXT_VALID;
  wire mem = tk && NEXT_REQ.kind inside
    {bcsch_pkg::BCSCH_CYC_FETCH, bcsch_pkg::BCSCH_CYC_DATA};
  wire cop = tk && NEXT_REQ.kind == bcsch_pkg::BCSCH_CYC_COPRO;
  AST_NOP: assert property ($past(CHIP_CLEAR) |->
    !MEM_CYCLE_NEXT_N && NEXT_ADDR_FOLLOWS) else $error("clear not no-op");
  AST_REFUSE: assert property (CHIP_CLEAR |-> !NEXT_READY)
    else $error("request taken in clear");
  AST_FETCH: assert property (mem |=> INSTR_FETCH_N ==
    $past(NEXT_REQ.kind[1])) else $error("fetch flag wrong");
  AST_MEM_NEXT: assert property (mem |=> !MEM_CYCLE_NEXT_N)
    else $error("memory cycle not flagged");
  AST_RNW: assert property (mem |=> READ_NOT_WRITE ==
    $past(NEXT_REQ.write)) else $error("direction wrong");
  AST_MAP: assert property (mem |=> MAP_ENABLE_N !=
    $past(NEXT_REQ.xlate)) else $error("translate flag wrong");
  AST_FOLLOWS: assert property (mem |=> NEXT_ADDR_FOLLOWS ==
    $past(NEXT_REQ.follows)) else $error("sequential flag wrong");
  AST_STROBE: assert property (cop |=> !COPRO_INSTR_N [*1])
    else $error("strobe not driven");
  AST_TRAP: assert property (UNDEF_TRAP |->
    COPRO_INSTR_N && $past(COPRO_ABSENT)) else $error("bad trap");
  AST_DONE: assert property (COPRO_DONE |->
    COPRO_INSTR_N && !$past(COPRO_BUSY) && !$past(COPRO_ABSENT))
    else $error("bad completion");
endmodule
bind bcsch_top bcsch_top_sva #(.DIV(DIV)) u_bcsch_top_sva (.CLK(CLK),
  .RSTN(RSTN), .CHIP_CLEAR(CHIP_CLEAR), .NEXT_REQ(NEXT_REQ),
  .NEXT_VALID(NEXT_VALID), .NEXT_READY(NEXT_READY),
  .COPRO_BUSY(COPRO_BUSY), .COPRO_ABSENT(COPRO_ABSENT),
  .COPRO_INSTR_N(COPRO_INSTR_N), .UNDEF_TRAP(UNDEF_TRAP),
  .COPRO_DONE(COPRO_DONE), .READ_NOT_WRITE(READ_NOT_WRITE),
  .MEM_CYCLE_NEXT_N(MEM_CYCLE_NEXT_N), .MAP_ENABLE_N(MAP_ENABLE_N),
  .INSTR_FETCH_N(INSTR_FETCH_N), .NEXT_ADDR_FOLLOWS(NEXT_ADDR_FOLLOWS));

/* testbench/bcsch_copro_model.sv */
// coprocessor model answering the handshake strobe
`timescale 1ns/1ps
module bcsch_copro_model (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // behaviour set by the bench
  input wire logic present,
  input wire logic [7:0] wait_cyc,
  // handshake
  input wire logic cop_n,
  output logic busy,
  output logic absent
);
  logic [7:0] cnt;
  logic tog;
  // cycles since strobe fell; tog keeps idle busy from looking meaningful
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 8'h00;
      tog <= 1'h0;
    end else begin
      cnt <= cop_n ? 8'h00 : cnt + 8'h01;
      tog <= ~tog;
    end
  end
  assign absent = present ? cop_n : 1'h1;
  assign busy = cop_n ? tog : (cnt < wait_cyc);
endmodule

/* testbench/tb_bcsch_top.sv */
// self-checking bench for the bus cycle status block
`timescale 1ns/1ps
module tb_bcsch_top;
  logic clk, rstn, clr, vld, rdy, busy, absent, present;
  logic rnw, mem_n, map_n, fetch_n, follows, cop_n, cs, rv, ut, cd;
  logic [7:0] wait_cyc;
  logic [9:0] exp_q[$], msk_q[$], mk, obs;
  bcsch_pkg::bcsch_req_t req;
  int err_count, check_count, seed, i;
  bcsch_top #(.DIV(2)) u_bcsch_top (.CLK(clk), .RSTN(rstn),
    .CHIP_CLEAR(clr), .NEXT_REQ(req), .NEXT_VALID(vld), .NEXT_READY(rdy),
    .COPRO_BUSY(busy), .COPRO_ABSENT(absent), .READ_NOT_WRITE(rnw),
    .MEM_CYCLE_NEXT_N(mem_n), .MAP_ENABLE_N(map_n),
    .INSTR_FETCH_N(fetch_n), .NEXT_ADDR_FOLLOWS(follows),
    .COPRO_INSTR_N(cop_n),
    .CYCLE_STROBE(cs), .RESET_VECTOR(rv), .UNDEF_TRAP(ut), .COPRO_DONE(cd));
  bcsch_copro_model u_bcsch_copro_model (.clk(clk), .rstn(rstn),
    .present(present), .wait_cyc(wait_cyc), .cop_n(cop_n), .busy(busy),
    .absent(absent));
  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic check(string name, logic [9:0] seen, logic [9:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic push(logic [9:0] e, logic [9:0] k);
    exp_q.push_back(e);
    msk_q.push_back(k);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // hold a request until taken; notes go in only then, so a late verdict
  // of the previous request cannot pop them
  task automatic send(bcsch_pkg::bcsch_kind_t k, logic verd);
    int n;
    int w;
    logic [9:0] e;
    @(negedge clk);
    req.kind = k;
    {req.write, req.follows, req.xlate} = 3'($random(seed));
    vld = 1'b1;
    for (n = 0; n < 40 && rdy !== 1'b1; n++) @(negedge clk);
    if (rdy !== 1'b1) begin
      err_count++;
      test_done();
    end
    // fetch_n equals kind bit 1: fetch is 1, data is 2
    e = {4'h4, req.write, 1'b0, !req.xlate, k[1], req.follows, 1'b1};
    if (k == bcsch_pkg::BCSCH_CYC_IDLE) push(10'h111, 10'h3D1);
    else if (k == bcsch_pkg::BCSCH_CYC_COPRO) push(10'h110, 10'h3D1);
    else push(e, 10'h3FF);
    if (k == bcsch_pkg::BCSCH_CYC_COPRO && verd)
      push(present ? 10'h041 : 10'h081, 10'h3C1);
    @(posedge clk);
    @(negedge clk);
    // wait out the verdict so the model's settings stay fixed meanwhile;
    // with DIV 2 the pins are sampled 2 clocks after the take, then every 4
    if (k == bcsch_pkg::BCSCH_CYC_COPRO && verd) begin
      w = present ? 2 + 4 * ((int'(wait_cyc) + 2) / 4) : 2;
      for (n = 0; n < 40 && cop_n !== 1'b1; n++) @(negedge clk);
      if (cop_n !== 1'b1) begin
        err_count++;
        test_done();
      end
      check("handshake", 10'(n), 10'(w));
    end
  endtask
  // each result pulse retires the oldest note
  always @(negedge clk) begin
    obs = {rv, cs, ut, cd, rnw, mem_n, map_n, fetch_n, follows, cop_n};
    if (rstn && (rv || cs || ut || cd)) begin
      mk = exp_q.size() > 0 ? msk_q.pop_front() : 10'h3FF;
      if (exp_q.size() == 0) check("unexpected", obs, 10'h000);
      else check("result", obs & mk, exp_q.pop_front() & mk);
    end
  end
  initial begin
    seed = 32'h1720;
    rstn = 1'b0;
    clr = 1'b1;
    vld = 1'b0;
    req = '0;
    present = 1'b1;
    wait_cyc = 8'h00;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    push(10'h20F, 10'h3FF);
    @(negedge clk);
    clr = 1'b0;
    // every kind back to back, coprocessor absent or slow in turn
    for (i = 0; i < 24; i++) begin
      wait_cyc = 8'(i % 7);
      present = (i % 5) != 3;
      send(bcsch_pkg::bcsch_kind_t'(i % 4), 1'b1);
    end
    $display("test kinds done");
    // clear during a stalled handshake gives no verdict
    wait_cyc = 8'h3C;
    present = 1'b1;
    send(bcsch_pkg::BCSCH_CYC_COPRO, 1'b0);
    @(negedge clk);
    vld = 1'b0;
    repeat (6) @(negedge clk);
    clr = 1'b1;
    repeat (3) @(negedge clk);
    check("strobe", {9'h000, cop_n}, 10'h001);
    push(10'h20F, 10'h3FF);
    clr = 1'b0;
    for (i = 0; i < 200 && exp_q.size() > 0; i++) @(negedge clk);
    if (exp_q.size() > 0) err_count++;
    $display("test clear done");
    test_done();
  end
endmodule
